// ==== common/p2pm_pkg.sv ====
// Constants, types and register map of the port 2 upper pin selector.
// Assumes one 100 MHz clock, a synchronous reset and an AHB-Lite master.
// Operation
// - Pin 6: I2C, timer, then GPIO/pulse
// - Channel 5 compare/PWM decode drives pin 6
// - Pin 6 feeds channel 5 capture when enabled
// - Pin 6 feeds irq14 only when selected
// - Pin 6 is converter trigger when selected
// - Bus wait owns pin 5 first
// - Wait input fed only when alternate selected
// - Mode 7 without bus ignores wait enable
// - Channel 4 B compare/PWM2 decode drives pin 5
// - Pin 5 feeds channel 4 B capture only with timer group 0
// - Pin 5 feeds irq13 only when selected
// - Pin 5 pulse only with pulse group 0
// - Pin 5 timer only with timer group 0
// - Pin 4: timer, receive, then GPIO/pulse
// - Channel 4 A compare/PWM decode drives pin 4; the code also needs timer group 0
// - Receive input takes pin 4 only if select 0
// - Pin 4 feeds channel 4 A capture; the code also needs timer group 0
// - Pin 4 feeds irq12 only when selected
// - Pin 4 pulse only with pulse group 0
package p2pm_pkg;
  localparam logic [7:0]  OFF_TMR5 = 8'h00;
  localparam logic [7:0]  OFF_TMR4 = 8'h04;
  localparam logic [7:0]  OFF_PORT = 8'h08;
  localparam logic [7:0]  OFF_SEL  = 8'h0C;
  localparam logic [7:0]  OFF_STAT = 8'h10;

  localparam logic [31:0] REG_RST   = 32'h0000_0000;
  localparam logic [31:0] MASK_TMR5 = 32'h0000_03FF;
  localparam logic [31:0] MASK_TMR4 = 32'h0000_3FFF;
  localparam logic [31:0] MASK_PORT = 32'h0000_0777;
  localparam logic [31:0] MASK_SEL  = 32'h0007_3FFF;

  // Timer register fields
  localparam int TMR_MODE_LSB = 0;
  localparam int TMR_IOA_LSB  = 4;
  localparam int TMR_IOB_LSB  = 8;
  localparam int TMR5_CLR_LSB = 8;
  localparam int TMR4_CLR_LSB = 12;
  // Port register fields, bit 0 of each is pin 4
  localparam int PORT_DIR_LSB = 0;
  localparam int PORT_PEN_LSB = 4;
  localparam int PORT_DAT_LSB = 8;
  // Select register bits
  localparam int SEL_IIC      = 0;
  localparam int SEL_IRQ14    = 1;
  localparam int SEL_IRQ13    = 2;
  localparam int SEL_IRQ12    = 3;
  localparam int SEL_EXTTRG   = 4;
  localparam int SEL_TRG_HI   = 5;
  localparam int SEL_TRG_LO   = 6;
  localparam int SEL_EXTBUS   = 7;
  localparam int SEL_WAIT_EN  = 8;
  localparam int SEL_WAIT_ALT = 9;
  localparam int SEL_PPG_GRP  = 10;
  localparam int SEL_TPU_GRP  = 11;
  localparam int SEL_RX_ON    = 12;
  localparam int SEL_RX_PIN   = 13;
  localparam int SEL_OPM_LSB  = 16;
  // Status register fields
  localparam int STAT_LVL_LSB = 0;
  localparam int STAT_FN4_LSB = 4;
  localparam int STAT_FN5_LSB = 8;
  localparam int STAT_FN6_LSB = 12;

  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PWM1   = 4'h2;
  localparam logic [3:0] MODE_PWM2   = 4'h3;
  localparam logic [1:0] CLR_BY_A    = 2'h1;
  localparam logic [1:0] CLR_BY_B    = 2'h2;
  localparam logic [2:0] OPM_1       = 3'h1;
  localparam logic [2:0] OPM_2       = 3'h2;
  localparam logic [2:0] OPM_4       = 3'h4;
  localparam logic [2:0] OPM_7       = 3'h7;

  typedef enum logic [2:0] {
    FN_INPUT, FN_GPIO, FN_PULSE, FN_TIMER, FN_IIC, FN_WAIT, FN_RX
  } p2pm_func_t;
endpackage

// ==== hw/p2pm_chan_dec.sv ====
// Decode of one timer pin: compare, PWM 1, PWM 2 and capture.
// Assumes mode, io and clear codes come from registers on the same clock.
module p2pm_chan_dec
  import p2pm_pkg::*;
#(
  parameter bit         PWM1_OK   = 1'b1,
  parameter logic [1:0] CLR_BLOCK = CLR_BY_A,
  parameter bit         CAP_TOP   = 1'b0
) (
  // Timer settings
  input  wire logic [3:0] mode,
  input  wire logic [3:0] io,
  input  wire logic [1:0] clr,
  // Decoded use of the pin
  output logic            drive,
  output logic            pwm1,
  output logic            capture
);
  logic normal;
  logic io_live;
  logic compare;
  logic pwm2;

  always_comb begin
    normal  = (mode == MODE_NORMAL) || (mode[3:2] == 2'b01);
    io_live = (io[1:0] != 2'b00);
    compare = normal && !io[3] && io_live;
    pwm1    = PWM1_OK && (mode == MODE_PWM1) && io_live;
    pwm2    = (mode == MODE_PWM2) && io_live && (clr != CLR_BLOCK);
    drive   = compare || pwm1 || pwm2;
    // Channel 5 A captures on the top bit alone, the others need 10xx
    capture = normal && (CAP_TOP ? io[3] : (io[3:2] == 2'b10));
  end
endmodule

// ==== hw/p2pm_sync.sv ====
// Three-stage pad synchroniser; a change counts once stages 2 and 3 agree.
// Assumes pad levels are asynchronous to CLOCK.
module p2pm_sync
  import p2pm_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Pad side and clean level
  input  wire logic [WIDTH-1:0] pad,
  output logic      [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } p2pm_sync_t;

  p2pm_sync_t st;
  p2pm_sync_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = pad;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.lvl[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;

  a_sync_hold: assert property (@(posedge clock) disable iff (reset)
    (st.s2 != st.s3) |=> (st.lvl == $past(st.lvl)))
    else $error("synchronised level moved while stages disagreed");
endmodule

// ==== hw/p2pm_top.sv ====
// Port 2 pins 6..4 function selector with AHB-Lite control registers.
// Assumes peripherals on CLOCK; pads asynchronous; single AHB slave.
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
module p2pm_top
  import p2pm_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA,
  // Pads, index is the pin number
  input  wire logic [6:4]  PIN_IN,
  output logic      [6:4]  PIN_OUT,
  output logic      [6:4]  PIN_OE,
  // Peripheral drive values
  input  wire logic        TIMER_A5_OUT,
  input  wire logic        TIMER_B4_OUT,
  input  wire logic        TIMER_A4_OUT,
  input  wire logic [6:4]  PULSE_OUT,
  input  wire logic        SERIAL_DATA_CH2_DRIVE_LOW,
  // Peripheral observers
  output logic             TIMER_A5_IN,
  output logic             TIMER_B4_IN,
  output logic             TIMER_A4_IN,
  output logic             TIMER_B5_DIS,
  output logic             IRQ14_ALT_N,
  output logic             IRQ13_ALT_N,
  output logic             IRQ12_ALT_N,
  output logic             CONV1_TRIG_N,
  output logic             WAIT_ALT_N,
  output logic             RX4_ALT,
  output logic             SERIAL_DATA_CH2_IN
);
  typedef struct packed {
    logic [31:0] tmr5;
    logic [31:0] tmr4;
    logic [31:0] port;
    logic [31:0] sel;
    logic        wr_pend;
    logic [7:0]  waddr;
    logic [31:0] rdata;
    logic [6:4]  pin_out;
    logic [6:4]  pin_oe;
    p2pm_func_t  fn4;
    p2pm_func_t  fn5;
    p2pm_func_t  fn6;
    logic        cap_a5;
    logic        cap_b4;
    logic        cap_a4;
    logic        b5_dis;
    logic        irq14;
    logic        irq13;
    logic        irq12;
    logic        trig;
    logic        wait_n;
    logic        rx4;
    logic        sda_in;
    logic        up;
  } p2pm_state_t;

  p2pm_state_t st;
  p2pm_state_t next_st;
  logic [6:4]  lvl;
  logic        drv_a5, pwm1_a5, cap_a5;
  logic        drv_b4, cap_b4;
  logic        drv_a4, cap_a4;
  logic        sel_iic, tpu_grp, ppg_grp, wait_act;
  logic [2:0]  opm, dir, pen, dat;

  p2pm_sync #(.WIDTH(3)) u_sync (
    .clock (CLOCK),
    .reset (RESET),
    .pad   (PIN_IN),
    .level (lvl)
  );

  p2pm_chan_dec #(.PWM1_OK(1'b1), .CLR_BLOCK(CLR_BY_A), .CAP_TOP(1'b1)) u_dec_a5 (
    .mode    (st.tmr5[TMR_MODE_LSB +: 4]),
    .io      (st.tmr5[TMR_IOA_LSB +: 4]),
    .clr     (st.tmr5[TMR5_CLR_LSB +: 2]),
    .drive   (drv_a5),
    .pwm1    (pwm1_a5),
    .capture (cap_a5)
  );

  p2pm_chan_dec #(.PWM1_OK(1'b0), .CLR_BLOCK(CLR_BY_B), .CAP_TOP(1'b0)) u_dec_b4 (
    .mode    (st.tmr4[TMR_MODE_LSB +: 4]),
    .io      (st.tmr4[TMR_IOB_LSB +: 4]),
    .clr     (st.tmr4[TMR4_CLR_LSB +: 2]),
    .drive   (drv_b4),
    .pwm1    (),
    .capture (cap_b4)
  );

  p2pm_chan_dec #(.PWM1_OK(1'b1), .CLR_BLOCK(CLR_BY_A), .CAP_TOP(1'b0)) u_dec_a4 (
    .mode    (st.tmr4[TMR_MODE_LSB +: 4]),
    .io      (st.tmr4[TMR_IOA_LSB +: 4]),
    .clr     (st.tmr4[TMR4_CLR_LSB +: 2]),
    .drive   (drv_a4),
    .pwm1    (),
    .capture (cap_a4)
  );

  // Pad enable and value for a chosen function, {oe, out}
  function automatic logic [1:0] pin_drive(input p2pm_func_t fn, input logic tv,
                                           input logic pv, input logic gv,
                                           input logic sl);
    unique case (fn)
      FN_GPIO:  pin_drive = {1'b1, gv};
      FN_PULSE: pin_drive = {1'b1, pv};
      FN_TIMER: pin_drive = {1'b1, tv};
      FN_IIC:   pin_drive = {sl, 1'b0};
      FN_INPUT: pin_drive = 2'b00;
      FN_WAIT:  pin_drive = 2'b00;
      FN_RX:    pin_drive = 2'b00;
      default:  pin_drive = 2'b00;
    endcase
  endfunction

  always_comb begin
    sel_iic  = st.sel[SEL_IIC];
    tpu_grp  = st.sel[SEL_TPU_GRP];
    ppg_grp  = st.sel[SEL_PPG_GRP];
    opm      = st.sel[SEL_OPM_LSB +: 3];
    dir      = st.port[PORT_DIR_LSB +: 3];
    pen      = st.port[PORT_PEN_LSB +: 3];
    dat      = st.port[PORT_DAT_LSB +: 3];
    // Mode 7 with the bus off never reaches this term
    wait_act = st.sel[SEL_EXTBUS] && st.sel[SEL_WAIT_EN] &&
               (opm == OPM_1 || opm == OPM_2 || opm == OPM_4 || opm == OPM_7);
  end

  always_comb begin
    next_st    = st;
    next_st.up = 1'b1;

    // Bus write lands in its data phase
    if (st.wr_pend) begin
      unique case (st.waddr)
        OFF_TMR5: next_st.tmr5 = HWDATA & MASK_TMR5;
        OFF_TMR4: next_st.tmr4 = HWDATA & MASK_TMR4;
        OFF_PORT: next_st.port = HWDATA & MASK_PORT;
        OFF_SEL:  next_st.sel  = HWDATA & MASK_SEL;
        default:  next_st.sel  = st.sel;
      endcase
    end
    next_st.wr_pend = 1'b0;
    if (HSEL && HREADY && HTRANS[1]) begin
      next_st.wr_pend = HWRITE && (HSIZE == 3'b010);
      next_st.waddr   = HADDR[7:0];
      // Read sees a write still in its data phase
      unique case (HADDR[7:0])
        OFF_TMR5: next_st.rdata = next_st.tmr5;
        OFF_TMR4: next_st.rdata = next_st.tmr4;
        OFF_PORT: next_st.rdata = next_st.port;
        OFF_SEL:  next_st.rdata = next_st.sel;
        OFF_STAT: begin
          next_st.rdata = REG_RST;
          next_st.rdata[STAT_LVL_LSB +: 3] = lvl;
          next_st.rdata[STAT_FN4_LSB +: 3] = st.fn4;
          next_st.rdata[STAT_FN5_LSB +: 3] = st.fn5;
          next_st.rdata[STAT_FN6_LSB +: 3] = st.fn6;
        end
        default:  next_st.rdata = REG_RST;
      endcase
    end

    // Pin 6 priority chain
    if (sel_iic) begin
      next_st.fn6 = FN_IIC;
    end else if (drv_a5) begin
      next_st.fn6 = FN_TIMER;
    end else if (!dir[2]) begin
      next_st.fn6 = FN_INPUT;
    end else if (pen[2]) begin
      next_st.fn6 = FN_PULSE;
    end else begin
      next_st.fn6 = FN_GPIO;
    end

    // Pin 5 priority chain
    if (wait_act) begin
      next_st.fn5 = FN_WAIT;
    end else if (drv_b4 && !tpu_grp) begin
      next_st.fn5 = FN_TIMER;
    end else if (!dir[1]) begin
      next_st.fn5 = FN_INPUT;
    end else if (pen[1] && !ppg_grp) begin
      next_st.fn5 = FN_PULSE;
    end else begin
      next_st.fn5 = FN_GPIO;
    end

    // Pin 4 priority chain; a blocked function falls to the next one
    if (drv_a4 && !tpu_grp) begin
      next_st.fn4 = FN_TIMER;
    end else if (st.sel[SEL_RX_ON] && !st.sel[SEL_RX_PIN]) begin
      next_st.fn4 = FN_RX;
    end else if (!dir[0]) begin
      next_st.fn4 = FN_INPUT;
    end else if (pen[0] && !ppg_grp) begin
      next_st.fn4 = FN_PULSE;
    end else begin
      next_st.fn4 = FN_GPIO;
    end

    {next_st.pin_oe[6], next_st.pin_out[6]} =
      pin_drive(next_st.fn6, TIMER_A5_OUT, PULSE_OUT[6], dat[2], SERIAL_DATA_CH2_DRIVE_LOW);
    {next_st.pin_oe[5], next_st.pin_out[5]} =
      pin_drive(next_st.fn5, TIMER_B4_OUT, PULSE_OUT[5], dat[1], 1'b0);
    {next_st.pin_oe[4], next_st.pin_out[4]} =
      pin_drive(next_st.fn4, TIMER_A4_OUT, PULSE_OUT[4], dat[0], 1'b0);

    // Observers read the pad whatever drives it; unselected ones idle high; b5_dis follows PWM 1 on channel 5 A instead
    next_st.irq14  = st.sel[SEL_IRQ14] ? lvl[6] : 1'b1;
    next_st.irq13  = st.sel[SEL_IRQ13] ? lvl[5] : 1'b1;
    next_st.irq12  = st.sel[SEL_IRQ12] ? lvl[4] : 1'b1;
    next_st.cap_a5 = cap_a5 ? lvl[6] : 1'b1;
    next_st.cap_b4 = (cap_b4 && !tpu_grp) ? lvl[5] : 1'b1;
    next_st.cap_a4 = (cap_a4 && !tpu_grp) ? lvl[4] : 1'b1;
    next_st.b5_dis = pwm1_a5;
    next_st.trig   = (!st.sel[SEL_EXTTRG] && st.sel[SEL_TRG_HI] &&
                      st.sel[SEL_TRG_LO]) ? lvl[6] : 1'b1;
    next_st.wait_n = (wait_act && st.sel[SEL_WAIT_ALT]) ? lvl[5] : 1'b1;
    next_st.rx4    = (next_st.fn4 == FN_RX) ? lvl[4] : 1'b1;
    next_st.sda_in = sel_iic ? lvl[6] : 1'b1;
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign HREADYOUT    = 1'b1;
  assign HRESP        = 1'b0;
  assign HRDATA       = st.rdata;
  assign PIN_OUT      = st.pin_out;
  assign PIN_OE       = st.pin_oe;
  assign TIMER_A5_IN  = st.cap_a5;
  assign TIMER_B4_IN  = st.cap_b4;
  assign TIMER_A4_IN  = st.cap_a4;
  assign TIMER_B5_DIS = st.b5_dis;
  assign IRQ14_ALT_N  = st.irq14;
  assign IRQ13_ALT_N  = st.irq13;
  assign IRQ12_ALT_N  = st.irq12;
  assign CONV1_TRIG_N = st.trig;
  assign WAIT_ALT_N   = st.wait_n;
  assign RX4_ALT      = st.rx4;
  assign SERIAL_DATA_CH2_IN = st.sda_in;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sequence s_rd_sel;
    HSEL && HREADY && HTRANS[1] && !HWRITE && (HADDR[7:0] == OFF_SEL) && !st.wr_pend;
  endsequence
  sequence s_pwm2_blocked;
    st.tmr5[TMR_MODE_LSB +: 4] == MODE_PWM2 && st.tmr5[TMR5_CLR_LSB +: 2] == CLR_BY_A;
  endsequence
  sequence s_pin6_plain_in;
    !st.sel[SEL_IIC] && !st.port[PORT_DIR_LSB + 2];
  endsequence

  a_bus_read: assert property (s_rd_sel |=> HRDATA == $past(st.sel))
    else $error("select register read back wrong");
  a_sda_pin6: assert property (st.up && $past(st.sel[SEL_IIC]) |->
    st.fn6 == FN_IIC && !PIN_OUT[6] && PIN_OE[6] == $past(SERIAL_DATA_CH2_DRIVE_LOW))
    else $error("pin 6 not handed to I2C data");
  a_pwm2_block: assert property ((s_pwm2_blocked and s_pin6_plain_in) |=>
    st.fn6 == FN_INPUT && !PIN_OE[6])
    else $error("pin 6 driven by blocked PWM 2");
  a_pwm1_b5: assert property (st.tmr5[TMR_MODE_LSB +: 4] == MODE_PWM1 &&
    st.tmr5[TMR_IOA_LSB +: 2] != 2'b00 |=> TIMER_B5_DIS)
    else $error("PWM 1 did not disable channel 5 B");
  a_cap_a5: assert property (st.up && $past(cap_a5) |-> TIMER_A5_IN == $past(lvl[6]))
    else $error("channel 5 capture not fed from pin 6");
  a_irq14_gate: assert property (st.up && !$past(st.sel[SEL_IRQ14]) |-> IRQ14_ALT_N)
    else $error("irq14 fed while unselected");
  a_trig_pin6: assert property (st.up && $past(st.sel[SEL_EXTTRG]) |-> CONV1_TRIG_N)
    else $error("trigger fed while external select is 1");
  a_wait_owns: assert property (wait_act |=> st.fn5 == FN_WAIT && !PIN_OE[5])
    else $error("pin 5 not released to bus wait");
  a_wait_alt: assert property (st.up && !$past(st.sel[SEL_WAIT_ALT]) |-> WAIT_ALT_N)
    else $error("wait input fed without alternate select");
  a_mode7_nowait: assert property (opm == OPM_7 && !st.sel[SEL_EXTBUS] |=>
    st.fn5 != FN_WAIT)
    else $error("wait enable honoured in mode 7 without bus");
  a_irq13_gate: assert property (st.up && $past(st.sel[SEL_IRQ13]) |->
    IRQ13_ALT_N == $past(lvl[5]))
    else $error("irq13 not fed from pin 5");
  a_group_sel: assert property (ppg_grp && tpu_grp |=>
    st.fn5 != FN_PULSE && st.fn5 != FN_TIMER && st.fn4 != FN_PULSE)
    else $error("pin group select ignored");
  a_rx_pin_sel: assert property (st.sel[SEL_RX_PIN] |=> st.fn4 != FN_RX && RX4_ALT)
    else $error("receive input took pin 4 while deselected");
endmodule

// ==== verification/p2pm_periph.sv ====
// Behavioural timer, pulse and I2C sources on the far side of the selector.
// Assumes the bench asks for levels; LAG sets how slowly they show up.
module p2pm_periph
#(
  parameter int LAG = 1
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Requested levels: timer a5, b4, a4, pulse 6..4, I2C low
  input  wire logic [6:0] want,
  // Peripheral drive values
  output logic            timer_a5,
  output logic            timer_b4,
  output logic            timer_a4,
  output logic [6:4]      pulse,
  output logic            sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] pipe [LAG];
  always_ff @(posedge clock) begin
    pipe[0] <= reset ? 7'h00 : want;
    for (int i = 1; i < LAG; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  assign {timer_a5, timer_b4, timer_a4, pulse, sda_low} = pipe[LAG-1];
endmodule

// ==== verification/p2pm_top_tb.sv ====
// Self-checking bench for the port 2 pins 6..4 function selector.
// Assumes the partner model feeds peripherals; ext is the outside pad level.
module p2pm_top_tb
  import p2pm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ITER = 150;
  logic        CLOCK = 1'h0;
  logic        RESET = 1'h1;
  logic        HSEL = 1'h0;
  logic        HWRITE = 1'h0;
  logic        rd_phase = 1'h0;
  logic        data_phase = 1'h0;
  logic        pin_chk = 1'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic [2:0]  HSIZE = 3'h2;
  logic        HREADYOUT, HRESP, SERIAL_DATA_CH2_DRIVE_LOW;
  logic        TIMER_A5_OUT, TIMER_B4_OUT, TIMER_A4_OUT;
  logic [31:0] HRDATA, r, t5, t4, pt, sl, exp_st;
  logic [6:4]  PIN_IN, PIN_OUT, PIN_OE, PULSE_OUT;
  logic [6:4]  ext = 3'h0;
  logic [6:0]  want = 7'h00;
  logic [10:0] obs;
  logic [16:0] exp_pin;
  // Start value 4216
  logic [15:0] seed = 16'h1078;
  logic [31:0] rd_q [$];
  logic [16:0] pin_q [$];
  int          mismatches = 0;
  int          check_count = 0;

  initial begin
    forever #5 CLOCK = ~CLOCK;
  end

  // Wire level from both parties
  assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & ext);

  p2pm_periph #(.LAG(2)) partner (.clock(CLOCK), .reset(RESET), .want(want),
    .timer_a5(TIMER_A5_OUT), .timer_b4(TIMER_B4_OUT), .timer_a4(TIMER_A4_OUT),
    .pulse(PULSE_OUT), .sda_low(SERIAL_DATA_CH2_DRIVE_LOW));

  p2pm_top dut (.CLOCK(CLOCK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .TIMER_A5_OUT(TIMER_A5_OUT), .TIMER_B4_OUT(TIMER_B4_OUT),
    .TIMER_A4_OUT(TIMER_A4_OUT), .PULSE_OUT(PULSE_OUT),
    .SERIAL_DATA_CH2_DRIVE_LOW(SERIAL_DATA_CH2_DRIVE_LOW),
    .TIMER_A5_IN(obs[10]), .TIMER_B4_IN(obs[9]), .TIMER_A4_IN(obs[8]),
    .TIMER_B5_DIS(obs[7]), .IRQ14_ALT_N(obs[6]), .IRQ13_ALT_N(obs[5]),
    .IRQ12_ALT_N(obs[4]), .CONV1_TRIG_N(obs[3]), .WAIT_ALT_N(obs[2]),
    .RX4_ALT(obs[1]), .SERIAL_DATA_CH2_IN(obs[0]));

  function automatic logic [31:0] rnd();
    logic [31:0] v;
    repeat (16) seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    v[31:16] = seed;
    repeat (16) seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    v[15:0] = seed;
    return v;
  endfunction

  // Address phase held until ready, then data phase held until ready
  task automatic ahb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [2:0] sz);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= we;
    HSIZE <= sz;
    do @(posedge CLOCK); while (HREADYOUT !== 1'h1);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rd_phase <= !we;
    data_phase <= 1'h1;
    do @(posedge CLOCK); while (HREADYOUT !== 1'h1);
    rd_phase <= 1'h0;
    data_phase <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d, 3'h2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    ahb(1'h0, a, 32'h0, 3'h2);
  endtask

  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD read data expected %h seen %h", e, s);
    end
  endtask

  task automatic cmp_resp(input logic e, input logic s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD response expected %h seen %h", e, s);
    end
  endtask

  task automatic cmp_pin(input logic [16:0] e, input logic [16:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD pins and observers expected %h seen %h", e, s);
    end
  endtask

  function automatic logic cls(input logic [3:0] m, input logic [3:0] io,
                               input logic [1:0] c, input logic [1:0] blk, input logic p1);
    return ((m == MODE_NORMAL || m[3:2] == 2'h1) && !io[3] && io[1:0] != 2'h0)
        || (m == MODE_PWM1 && p1 && io[1:0] != 2'h0)
        || (m == MODE_PWM2 && io[1:0] != 2'h0 && c != blk);
  endfunction

  function automatic p2pm_func_t dp(input logic dir, input logic pen, input logic grp);
    return !dir ? FN_INPUT : (pen && !grp) ? FN_PULSE : FN_GPIO;
  endfunction

  // Drive enable and value of one pad
  function automatic logic [1:0] drv(input p2pm_func_t f, input logic d, input logic p,
                                     input logic t, input logic s);
    case (f)
      FN_GPIO:  return {1'h1, d};
      FN_PULSE: return {1'h1, p};
      FN_TIMER: return {1'h1, t};
      FN_IIC:   return {s, 1'h0};
      default:  return 2'h0;
    endcase
  endfunction

  task automatic predict();
    p2pm_func_t f6, f5, f4;
    logic [1:0] d6, d5, d4;
    logic [6:4] oe, lv;
    logic       wt, tg, n5, n4;
    tg = sl[SEL_TPU_GRP];
    n5 = t5[3:0] == MODE_NORMAL || t5[3:2] == 2'h1;
    n4 = t4[3:0] == MODE_NORMAL || t4[3:2] == 2'h1;
    wt = sl[SEL_EXTBUS] && sl[SEL_WAIT_EN]
      && sl[18:16] inside {OPM_1, OPM_2, OPM_4, OPM_7};
    f6 = sl[SEL_IIC] ? FN_IIC : cls(t5[3:0], t5[7:4], t5[9:8], CLR_BY_A, 1'h1) ? FN_TIMER
       : dp(pt[2], pt[6], 1'h0);
    f5 = wt ? FN_WAIT : cls(t4[3:0], t4[11:8], t4[13:12], CLR_BY_B, 1'h0) && !tg ? FN_TIMER
       : dp(pt[1], pt[5], sl[SEL_PPG_GRP]);
    f4 = cls(t4[3:0], t4[7:4], t4[13:12], CLR_BY_A, 1'h1) && !tg ? FN_TIMER
       : sl[SEL_RX_ON] && !sl[SEL_RX_PIN] ? FN_RX
       : dp(pt[0], pt[4], sl[SEL_PPG_GRP]);
    d6 = drv(f6, pt[10], want[3], want[6], want[0]);
    d5 = drv(f5, pt[9], want[2], want[5], want[0]);
    d4 = drv(f4, pt[8], want[1], want[4], want[0]);
    oe = {d6[1], d5[1], d4[1]};
    lv = (oe & {d6[0], d5[0], d4[0]}) | (~oe & ext);
    exp_st = {17'h0, f6, 1'h0, f5, 1'h0, f4, 1'h0, lv};
    exp_pin = {oe, oe & {d6[0], d5[0], d4[0]},
      lv[6] | ~(n5 & t5[7]),
      lv[5] | ~(n4 && t4[11:10] == 2'h2 && !tg),
      lv[4] | ~(n4 && t4[7:6] == 2'h2 && !tg),
      t5[3:0] == MODE_PWM1 && t5[5:4] != 2'h0,
      lv[6] | ~sl[SEL_IRQ14],
      lv[5] | ~sl[SEL_IRQ13],
      lv[4] | ~sl[SEL_IRQ12],
      lv[6] | ~(!sl[SEL_EXTTRG] && sl[SEL_TRG_HI] && sl[SEL_TRG_LO]),
      lv[5] | ~(wt && sl[SEL_WAIT_ALT]),
      lv[4] | (f4 != FN_RX),
      lv[6] | ~sl[SEL_IIC]};
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Pads are only compared where driven; an idle value carries no meaning
  always @(posedge CLOCK) begin
    if (rd_phase && HREADYOUT === 1'h1) cmp_rd(rd_q.pop_front(), HRDATA);
    if (data_phase) cmp_resp(1'h0, HRESP);
    if (pin_chk) cmp_pin(pin_q.pop_front(), {PIN_OE, PIN_OUT & PIN_OE, obs});
  end

  initial begin
    repeat (ITER * 60 + 2000) @(posedge CLOCK);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge CLOCK);
    RESET <= 1'h0;
    @(posedge CLOCK);
    for (int a = 0; a < 24; a += 4) rd(a[7:0], 32'h0);
    for (int i = 0; i < ITER; i++) begin
      r = rnd();
      ext <= r[2:0];
      want <= r[9:3];
      r = rnd();
      wr(OFF_TMR5, r);
      t5 = r & MASK_TMR5;
      r = rnd();
      wr(OFF_TMR4, r);
      t4 = r & MASK_TMR4;
      r = rnd();
      wr(OFF_PORT, r);
      pt = r & MASK_PORT;
      r = rnd();
      wr(OFF_SEL, r);
      sl = r & MASK_SEL;
      // Room for the partner lag and the pad synchroniser
      repeat (10) @(posedge CLOCK);
      predict();
      pin_q.push_back(exp_pin);
      pin_chk <= 1'h1;
      @(posedge CLOCK);
      pin_chk <= 1'h0;
      rd(OFF_SEL, sl);
      rd(OFF_STAT, exp_st);
    end
    wr(OFF_STAT, 32'hFFFF_FFFF);
    wr(8'h14, 32'hFFFF_FFFF);
    ahb(1'h1, OFF_SEL, ~sl, 3'h0);
    rd(OFF_SEL, sl);
    rd(8'h14, 32'h0);
    rd(OFF_STAT, exp_st);
    @(posedge CLOCK);
    stop_test();
  end
endmodule
